// File: shared/bam_pkg.sv
// package: constants, types and state record of the battery arming mode controller
package bam_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ           = 125_000_000;
  localparam int     T_ARM_HOLD_MS    = 2000;    // 2 seconds
  localparam int     T_DISARM_HOLD_MS = 3000;    // 3 seconds
  localparam int     T_BATT_HOLD_MS   = 3000;    // three seconds
  localparam int     T_ARMED_MS       = 600_000; // ten minutes
  localparam int     T_OFF_SHOW_MS    = 1000;
  localparam longint CC_FREQ_CHZ      = 925;     // 9.25 Hz in hundredths
  localparam int     MS_CYCLES        = int'(CLK_HZ / 1000);
  localparam int     CC_HALF_CYCLES   = int'((CLK_HZ * 100) / (CC_FREQ_CHZ * 2));

  localparam int MS_W   = 17;
  localparam int HOLD_W = 20;
  localparam int CC_W   = 23;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 4;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_REMAIN = 4'h8;
  localparam int         CTRL_BIT_TEST  = 0;
  localparam int         CTRL_ERR_CLEAR = 1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_EXT    = 4'b0001,
    MODE_BATT   = 4'b0010,
    MODE_OFFMSG = 4'b0100,
    MODE_DOWN   = 4'b1000
  } bam_mode_e;

  typedef struct packed {
    logic lever_ccw;     // lever held toward standby
    logic lever_cw;      // lever held toward normal
    logic soc_high;      // state-of-charge status, high = depleted
    logic module_sense;  // termination resistance seen on count clock line
    logic fuse_ok;       // fuse test tap present
    logic ac_ok;
    logic dc_ok;
    logic supply18_low;  // locally derived 18 V below threshold
    logic link_fail;     // remote altitude source failed
  } bam_pins_s;

  typedef struct packed {
    logic armed;
    logic battery;
    logic batt_err;
    logic standby;
    logic off_msg;
    logic remote_altitude_mode;
    logic count_clk;
    logic batt_power_en;
    logic discharge_inhibit;
  } bam_ind_s;

  typedef struct packed {
    bam_pins_s             sync1;
    bam_pins_s             sync2;
    bam_pins_s             prev;
    logic [MS_W-1:0]       ms_cnt;
    logic                  ms_tick;
    logic [HOLD_W-1:0]     hold_internal_sensor_mode;
    logic [HOLD_W-1:0]     hold_remote_altitude_mode;
    logic                  internal_sensor_mode_done;
    logic                  arm_ready;
    logic                  remote_altitude_mode_done;
    logic [HOLD_W-1:0]     arm_left;
    logic [HOLD_W-1:0]     off_left;
    logic [CC_W-1:0]       cc_cnt;
    bam_mode_e             mode;
    bam_ind_s              ind;
    logic                  waitreq;
    logic [31:0]           rdata;
  } bam_state_s;

endpackage

// File: design/bam_ctrl.sv
// battery arming, mode lever and count clock controller with avalon-mm registers
`timescale 1ns/1ps
`default_nettype none

module bam_ctrl #(
  parameter int MS_CYC   = bam_pkg::MS_CYCLES,
  parameter int CC_HALF  = bam_pkg::CC_HALF_CYCLES,
  parameter int ARM_MS   = bam_pkg::T_ARM_HOLD_MS,
  parameter int DISARM_MS = bam_pkg::T_DISARM_HOLD_MS,
  parameter int BATT_MS  = bam_pkg::T_BATT_HOLD_MS,
  parameter int ARMED_MS = bam_pkg::T_ARMED_MS,
  parameter int OFF_MS   = bam_pkg::T_OFF_SHOW_MS
) (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic [bam_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output var  logic [31:0]               avs_readdata,
  output var  logic                      avs_waitrequest,
  input  wire bam_pkg::bam_pins_s        pins,
  output var  bam_pkg::bam_ind_s         ind
);
  import bam_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bam_state_s s_q;
  bam_state_s s_d;

  logic ext_pwr;
  logic mod_in;
  logic arm_evt;
  logic disarm_lever;
  logic batt_start;
  logic off_start;
  logic cc_run;
  logic acc;
  logic wr_ctrl;

  // hold counter step, saturating at its target
  function automatic logic [HOLD_W-1:0] hold_step(input logic held,
                                                  input logic tick,
                                                  input logic [HOLD_W-1:0] cnt,
                                                  input logic [HOLD_W-1:0] lim);
    if (!held)
      return '0;
    if (tick && cnt != lim)
      return cnt + 1'b1;
    return cnt;
  endfunction

  assign ext_pwr = s_q.sync2.ac_ok | s_q.sync2.dc_ok;
  assign mod_in  = s_q.sync2.module_sense;
  assign acc     = (avs_read | avs_write) & s_q.waitreq;
  assign wr_ctrl = avs_write & !s_q.waitreq & (avs_address == ADDR_CTRL);

  // ----------------------------------------------------------------
  // lever events
  // ----------------------------------------------------------------
  // arming fires on release, so a hold shorter than the limit never arms
  assign arm_evt = s_q.prev.lever_ccw & !s_q.sync2.lever_ccw & s_q.arm_ready
                   & ext_pwr & mod_in & !s_q.ind.armed;
  assign disarm_lever = s_q.remote_altitude_mode_done == 1'b0
                        && s_q.hold_remote_altitude_mode == HOLD_W'(DISARM_MS)
                        && s_q.mode == MODE_EXT && s_q.ind.armed;
  assign batt_start = !s_q.internal_sensor_mode_done && s_q.hold_internal_sensor_mode == HOLD_W'(BATT_MS)
                      && !ext_pwr && mod_in && s_q.mode == MODE_EXT;
  assign off_start = !s_q.remote_altitude_mode_done && s_q.hold_remote_altitude_mode == HOLD_W'(DISARM_MS)
                     && !ext_pwr && s_q.mode == MODE_BATT;
  assign cc_run = s_q.sync2.supply18_low && s_q.mode == MODE_BATT;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;

    // millisecond enable
    s_d.ms_tick = 1'b0;
    if (s_q.ms_cnt == MS_W'(MS_CYC - 1)) begin
      s_d.ms_cnt  = '0;
      s_d.ms_tick = 1'b1;
    end else begin
      s_d.ms_cnt = s_q.ms_cnt + 1'b1;
    end

    // hold timers
    s_d.hold_internal_sensor_mode = hold_step(s_q.sync2.lever_ccw, s_q.ms_tick, s_q.hold_internal_sensor_mode,
                              HOLD_W'(BATT_MS));
    s_d.hold_remote_altitude_mode = hold_step(s_q.sync2.lever_cw, s_q.ms_tick, s_q.hold_remote_altitude_mode,
                              HOLD_W'(DISARM_MS));
    if (!s_q.sync2.lever_ccw)
      s_d.internal_sensor_mode_done = 1'b0;
    else if (batt_start)
      s_d.internal_sensor_mode_done = 1'b1;
    if (!s_q.sync2.lever_cw)
      s_d.remote_altitude_mode_done = 1'b0;
    else if (s_q.hold_remote_altitude_mode == HOLD_W'(DISARM_MS))
      s_d.remote_altitude_mode_done = 1'b1;
    if (!s_q.sync2.lever_ccw && !s_q.prev.lever_ccw)
      s_d.arm_ready = 1'b0;
    else if (s_q.hold_internal_sensor_mode >= HOLD_W'(ARM_MS))
      s_d.arm_ready = 1'b1;

    // mode selection, also during the armed period
    if (s_q.sync2.lever_cw && !s_q.prev.lever_cw && s_q.mode == MODE_EXT)
      s_d.ind.remote_altitude_mode = 1'b1;
    if (s_q.sync2.lever_ccw && !s_q.prev.lever_ccw)
      s_d.ind.remote_altitude_mode = 1'b0;
    if (s_q.sync2.link_fail)
      s_d.ind.remote_altitude_mode = 1'b0;

    // arming and the armed period
    if (arm_evt) begin
      s_d.ind.armed = 1'b1;
      s_d.arm_left  = HOLD_W'(ARMED_MS);
    end else if (s_q.ind.armed) begin
      if (disarm_lever || !mod_in)
        s_d.ind.armed = 1'b0;
      else if (s_q.ms_tick) begin
        s_d.arm_left = s_q.arm_left - 1'b1;
        if (s_q.arm_left == HOLD_W'(1))
          s_d.ind.armed = 1'b0;
      end
    end

    // power mode machine
    case (s_q.mode)
      MODE_EXT: begin
        // dc loss alone leaves the mode untouched while ac holds
        if ((!ext_pwr && s_q.ind.armed && mod_in) || batt_start) begin
          s_d.mode = MODE_BATT;
          s_d.ind.remote_altitude_mode = 1'b0;
        end
      end
      MODE_BATT: begin
        if (ext_pwr)
          s_d.mode = MODE_EXT;
        else if (off_start) begin
          s_d.mode     = MODE_OFFMSG;
          s_d.off_left = HOLD_W'(OFF_MS);
        end
      end
      MODE_OFFMSG: begin
        if (s_q.ms_tick) begin
          s_d.off_left = s_q.off_left - 1'b1;
          if (s_q.off_left == HOLD_W'(1))
            s_d.mode = MODE_DOWN;
        end
      end
      MODE_DOWN: begin
        if (ext_pwr)
          s_d.mode = MODE_EXT;
      end
      default: s_d.mode = MODE_EXT;
    endcase

    // indications
    s_d.ind.battery       = (s_d.mode == MODE_BATT);
    s_d.ind.off_msg       = (s_d.mode == MODE_OFFMSG);
    s_d.ind.batt_power_en = (s_d.mode == MODE_BATT) || (s_d.mode == MODE_OFFMSG);
    s_d.ind.discharge_inhibit = ext_pwr;
    s_d.ind.standby = !s_d.ind.remote_altitude_mode;

    // battery error: software clear loses to any setting cause
    if (wr_ctrl && avs_writedata[CTRL_ERR_CLEAR])
      s_d.ind.batt_err = 1'b0;
    if (mod_in) begin
      if (s_q.sync2.soc_high)
        s_d.ind.batt_err = 1'b1;
      if (arm_evt && (!s_q.sync2.fuse_ok || s_q.sync2.soc_high))
        s_d.ind.batt_err = 1'b1;
      if (wr_ctrl && avs_writedata[CTRL_BIT_TEST] && !s_q.sync2.fuse_ok)
        s_d.ind.batt_err = 1'b1;
    end else begin
      s_d.ind.batt_err = 1'b0;
    end

    // count clock: a high half, then low half while running
    if (arm_evt) begin
      s_d.ind.count_clk = 1'b1;
      s_d.cc_cnt        = '0;
    end else if (s_q.cc_cnt == CC_W'(CC_HALF - 1)) begin
      s_d.cc_cnt = '0;
      if (s_q.ind.count_clk)
        s_d.ind.count_clk = 1'b0;
      else if (cc_run)
        s_d.ind.count_clk = 1'b1;
    end else if (s_q.ind.count_clk || cc_run) begin
      s_d.cc_cnt = s_q.cc_cnt + 1'b1;
    end else begin
      s_d.cc_cnt = '0;
    end

    // avalon slave: one wait cycle, then the answer
    s_d.waitreq = !acc;
    if (acc) begin
      case (avs_address)
        ADDR_CTRL:   s_d.rdata = '0;
        ADDR_STATUS: s_d.rdata = {19'h0, s_q.mode, s_q.ind};
        ADDR_REMAIN: s_d.rdata = {12'h0, s_q.arm_left};
        default:     s_d.rdata = '0;
      endcase
    end

    if (reset) begin
      s_d = '0;
      s_d.mode    = MODE_EXT;
      s_d.waitreq = 1'b1;
      s_d.ind.standby = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign ind             = s_q.ind;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_reset_quiet: assert property (@(posedge clk_sys) disable iff (1'b0)
    reset |=> !ind.armed && !ind.count_clk && !ind.battery)
    else $error("outputs not quiet after reset");
  a_ext_inhibit: assert property (ext_pwr |=> ind.discharge_inhibit)
    else $error("discharge not inhibited on external power");
  a_soc_error: assert property (s_q.sync2.soc_high && mod_in |=> ind.batt_err)
    else $error("depleted charge not flagged");
  a_arm_pulse: assert property ($rose(ind.armed) |-> ind.count_clk
    && s_q.cc_cnt == '0)
    else $error("no count pulse at arming");
  a_lever_disarm: assert property (disarm_lever |=> !ind.armed)
    else $error("armed flag kept after lever disarm");
  a_no_module: assert property (!mod_in |=> !ind.armed && !ind.batt_err)
    else $error("battery display without module");
  // failure revert and every non-external mode must show the flag
  a_standby_flag: assert property (
    s_q.sync2.link_fail || s_q.mode != MODE_EXT |=> ind.standby)
    else $error("standby flag missing in standby operation");
  a_dc_loss_quiet: assert property (
    ind.remote_altitude_mode && s_q.sync2.ac_ok && !s_q.sync2.link_fail
    && !s_q.sync2.lever_ccw |=> !ind.standby)
    else $error("standby flag shown on dc loss in remote mode");
  a_lost_power: assert property (
    s_q.mode == MODE_EXT && !ext_pwr && ind.armed && mod_in
    |=> ind.battery && ind.batt_power_en)
    else $error("no battery takeover on power loss");
  a_arm_release: assert property (arm_evt |=> ind.armed ##1 ind.armed)
    else $error("arming lost");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

  c_arm: cover property ($rose(ind.armed));
  c_batt: cover property ($rose(ind.battery));
  c_off: cover property ($rose(ind.off_msg));
  c_err: cover property ($rose(ind.batt_err));

endmodule

`default_nettype wire

// File: tb/bam_batt_model.sv
// model of the removable battery module: charge counter, termination, fuse tap
`timescale 1ns/1ps
`default_nettype none
module bam_batt_model #(
  parameter int EXPIRE = 1000
) (
  input  wire logic        clk_sys,
  input  wire logic        count_clk,
  input  wire logic        present,
  input  wire logic        fuse_good,
  input  wire logic        spent,
  output var  logic        soc_high,
  output var  logic        module_sense,
  output var  logic        fuse_ok,
  output var  logic [15:0] pulses
);
  logic        cc_q  = 1'b0;
  logic [15:0] cnt_q = 16'h0;
  // counter only sees edges while the module is plugged in
  always @(posedge clk_sys) begin
    cc_q <= count_clk;
    if (present && count_clk && !cc_q) cnt_q <= cnt_q + 16'h1;
  end
  assign pulses = cnt_q;
  // an absent module leaves every line at ground
  assign soc_high     = present && (spent || cnt_q >= EXPIRE[15:0]);
  assign module_sense = present;
  assign fuse_ok      = present && fuse_good;
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench of the battery arming mode controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bam_pkg::*;
  localparam int MS = 10, HALF = 20, ARM = 4, DIS = 6, BAT = 6, ARMD = 50, OFF = 5;
  logic        clk_sys, reset, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  bam_pins_s   pins;
  bam_ind_s    ind;
  logic        ccw, cw, ac_ok, dc_ok, low18, link_fail, present, fuse_good, spent;
  logic        soc_high, module_sense, fuse_ok;
  logic [15:0] pulses, p0;
  int          n_mismatch, num_checks, seed, i, t;

  assign pins = {ccw, cw, soc_high, module_sense, fuse_ok, ac_ok, dc_ok, low18, link_fail};
  bam_ctrl #(.MS_CYC(MS), .CC_HALF(HALF), .ARM_MS(ARM), .DISARM_MS(DIS), .BATT_MS(BAT),
    .ARMED_MS(ARMD), .OFF_MS(OFF)) bam_ctrl_i (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pins(pins), .ind(ind));
  bam_batt_model bam_batt_model_i (.clk_sys(clk_sys), .count_clk(ind.count_clk),
    .present(present), .fuse_good(fuse_good), .spent(spent), .soc_high(soc_high),
    .module_sense(module_sense), .fuse_ok(fuse_ok), .pulses(pulses));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic int cyc(input int ms);
    return ms * MS;
  endfunction

  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until an edge that sees waitrequest low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task hold(input bit to_ccw, input int ms, input bit rel);
    @(posedge clk_sys);
    if (to_ccw) ccw <= 1'b1;
    else cw <= 1'b1;
    repeat (cyc(ms)) @(posedge clk_sys);
    if (rel) begin
      ccw <= 1'b0;
      cw <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task span(input logic lvl, output int n);
    n = 0;
    while (ind.count_clk === lvl && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    {n_mismatch, num_checks, seed} = {32'h0, 32'h0, 32'd96};
    {reset, avs_read, avs_write, avs_address, avs_writedata} = {3'b100, 36'h0};
    {ccw, cw, ac_ok, dc_ok, low18, link_fail, present, fuse_good, spent} = 9'b001100110;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    wait_n(4);
    chk("armed", ind.armed, 0);
    chk("battery", ind.battery, 0);
    chk("count_clk", ind.count_clk, 0);
    chk("discharge_inhibit", ind.discharge_inhibit, 1);
    bus(1'b0, ADDR_STATUS, 0);
    chk("status_mode", rd[12:9], MODE_EXT);
    bus(1'b0, 4'hc, 0);
    chk("unmapped", rd, 0);
    // random short holds must never arm
    for (i = 0; i < 3; i++) begin
      hold(1, 1 + ($unsigned($random(seed)) % (ARM - 1)), 1);
      chk("armed_short", ind.armed, 0);
    end
    @(posedge clk_sys);
    present <= 1'b0;
    hold(1, ARM + 1, 1);
    chk("armed_nomod", ind.armed, 0);
    @(posedge clk_sys);
    present <= 1'b1;
    p0 = pulses;
    hold(1, ARM + 1, 1);
    chk("armed", ind.armed, 1);
    chk("standby", ind.standby, 1);
    chk("remote", ind.remote_altitude_mode, 0);
    wait_n(3 * HALF);
    chk("arm_pulses", pulses - p0, 1);
    hold(0, 1, 1);
    chk("remote", ind.remote_altitude_mode, 1);
    chk("standby", ind.standby, 0);
    chk("armed_kept", ind.armed, 1);
    @(posedge clk_sys);
    dc_ok <= 1'b0;
    wait_n(6);
    chk("standby_dc", ind.standby, 0);
    @(posedge clk_sys);
    {dc_ok, link_fail} <= 2'b11;
    wait_n(6);
    chk("standby_fail", ind.standby, 1);
    @(posedge clk_sys);
    link_fail <= 1'b0;
    hold(0, DIS + 1, 0);
    chk("disarm", ind.armed, 0);
    // open fuse at the moment of arming
    @(posedge clk_sys);
    {cw, fuse_good} <= 2'b00;
    hold(1, ARM + 1, 1);
    chk("err_arm_fuse", ind.batt_err, 1);
    wait_n(cyc(ARMD - 10));
    chk("armed_period", ind.armed, 1);
    wait_n(cyc(15));
    chk("auto_disarm", ind.armed, 0);
    bus(1'b0, ADDR_REMAIN, 0);
    chk("remain", rd, 0);
    @(posedge clk_sys);
    fuse_good <= 1'b1;
    hold(1, ARM + 1, 1);
    @(posedge clk_sys);
    {low18, ac_ok, dc_ok} <= 3'b100;
    wait_n(8);
    chk("battery", ind.battery, 1);
    chk("batt_power", ind.batt_power_en, 1);
    span(0, t);
    span(1, t);
    span(0, t);
    chk("cc_low", t, HALF);
    span(1, t);
    chk("cc_high", t, HALF);
    hold(0, BAT + 1, 0);
    chk("off_msg", ind.off_msg, 1);
    wait_n(cyc(OFF + 1));
    chk("power_off", ind.batt_power_en, 0);
    @(posedge clk_sys);
    {cw, reset} <= 2'b01;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    wait_n(2);
    chk("armed_rst", ind.armed, 0);
    hold(1, BAT + 1, 1);
    chk("battery_hold", ind.battery, 1);
    @(posedge clk_sys);
    {ac_ok, dc_ok, low18, spent} <= 4'b1101;
    wait_n(8);
    chk("err_soc", ind.batt_err, 1);
    @(posedge clk_sys);
    spent <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h2);
    wait_n(4);
    chk("err_clear", ind.batt_err, 0);
    @(posedge clk_sys);
    fuse_good <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h1);
    wait_n(4);
    chk("err_fuse", ind.batt_err, 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
